// ---- rtl/port_latch_pkg.sv ----
package port_latch_pkg;

	localparam logic [7:0] PORT_ZERO_LATCH_ADDR = 8'h80;
	localparam logic [7:0] PORT_ONE_LATCH_ADDR = 8'h90;
	localparam logic [7:0] PORT_TWO_LATCH_ADDR = 8'hA0;
	localparam logic [7:0] PORT_TWO_PULLUP_DISABLE_ADDR = 8'hB4;

	localparam logic [7:0] PORT_ZERO_RESET = 8'hFF;
	localparam logic [7:0] PORT_ONE_RESET = 8'hFF;
	localparam logic [7:0] PORT_TWO_RESET = 8'hFF;
	localparam logic [7:0] PORT_TWO_UNUSED_ONES = 8'hFC;
	localparam logic [7:0] PULLUP_DISABLE_RESET = 8'h00;
	localparam logic [7:0] PULLUP_DISABLE_MASK = 8'h37;
	localparam logic [7:0] READ_MISS_DATA = 8'h00;

	localparam int PUD_RESET_PIN_BIT = 5;
	localparam int PUD_EA_PIN_BIT = 4;
	localparam int P2_PIN_COUNT = 2;
	localparam int P2_PULLUP_COUNT = 3;

	localparam int BIT_ADDR_SEL_MSB = 7;
	localparam int BIT_ADDR_SEL_LSB = 3;
	localparam int BIT_ADDR_POS_MSB = 2;

	localparam int P0_BATTERY_PIN = 0;
	localparam int P0_SEGMENT_PIN = 1;
	localparam int P0_CALIB_ONE_PIN = 2;
	localparam int P0_CALIB_TWO_PIN = 3;
	localparam int P0_SERIAL_DATA_PIN = 4;

	localparam logic [1:0] BATTERY_CTRL_PATTERN = 2'b01;
	localparam logic [1:0] SLEEP_WAKE_PATTERN = 2'b11;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic rmw;
		logic [7:0] wdata;
		logic bit_wr;
		logic [7:0] bit_addr;
		logic bit_wdata;
	} sfr_req_t;

	typedef struct packed {
		logic [2:0] irq_pin_program_field;
		logic external_irq_one_enable;
		logic segment_19_enable;
		logic lcd_segment_19;
		logic calib_out_one_disable;
		logic calib_out_two_disable;
		logic calib_freq_out_one;
		logic calib_freq_out_two;
		logic serial_port_select;
		logic spi_block_enable;
		logic spi_mosi_out;
		logic two_wire_enable;
		logic two_wire_data_out;
	} alt_ctrl_t;

	typedef struct packed {
		logic battery_control_in;
		logic external_irq_one;
		logic battery_sleep_wake;
		logic spi_mosi_in;
		logic two_wire_data_in;
	} alt_in_t;

endpackage

// ---- rtl/port_latch_pullup_altfunc.sv ----
`timescale 1ns/1ps
// Functional notes
// - Pull-up disable bit 5 frees reset pin
// - Pull-up disable bit 4 frees access pin
// - Bits 2..0 disable port-two pin pull-ups
// - Port zero latch, bit-addressable, resets ones
// - Port one latch, bit-addressable, resets ones
// - Port two bits 1..0 drive pins
// - Port two bits 7..2 stay set
// - Pin 0.0 battery control on X01
// - Pin 0.0 sleep wake on 11X
// - Pin 0.0 external interrupt one when enabled
// - Pin 0.1 segment 19 when enabled
// - Pins 0.2/0.3 calibration outputs unless disabled
// - Pin 0.4 SPI MOSI when selected
// - Pin 0.4 two-wire data when selected
// - Alternate only with latch one, else pin low and forwarded input high
// - Pull-up disabled means open drain
// - Writes load latch; RMW reads latch
module port_latch_pullup_altfunc (
	input wire logic I_CLK_SYS,
	input wire logic I_SRST,
	input port_latch_pkg::sfr_req_t I_SFR_REQ,
	output logic [7:0] O_SFR_RDATA,
	input port_latch_pkg::alt_ctrl_t I_ALT_CTRL,
	output port_latch_pkg::alt_in_t O_ALT_IN,
	input wire logic [7:0] I_P0_PIN,
	output logic [7:0] O_P0_OUT,
	output logic [7:0] O_P0_OE,
	input wire logic [7:0] I_P1_PIN,
	output logic [7:0] O_P1_OUT,
	output logic [7:0] O_P1_OE,
	input wire logic [1:0] I_P2_PIN,
	output logic [1:0] O_P2_OUT,
	output logic [1:0] O_P2_OE,
	output logic [2:0] O_P2_PULLUP_EN,
	output logic O_RESET_PIN_PULLUP_EN,
	output logic O_EA_PIN_PULLUP_EN
);
	import port_latch_pkg::*;

	typedef struct packed {
		logic [7:0] p0_r;
		logic [7:0] p1_r;
		logic [7:0] p2_r;
		logic [7:0] pud2_r;
		logic [7:0] p0_meta;
		logic [7:0] p0_sync;
		logic [7:0] p1_meta;
		logic [7:0] p1_sync;
		logic [1:0] p2_meta;
		logic [1:0] p2_sync;
		logic [7:0] rdata;
		logic [7:0] p0_out;
		logic [7:0] p0_oe;
		logic [7:0] p1_out;
		logic [7:0] p1_oe;
		logic [1:0] p2_out;
		logic [1:0] p2_oe;
		logic [2:0] p2_pu;
		logic rst_pu;
		logic ea_pu;
		alt_in_t alt_in;
	} state_t;

	localparam state_t STATE_RESET = '{
		p0_r: PORT_ZERO_RESET,
		p1_r: PORT_ONE_RESET,
		p2_r: PORT_TWO_RESET,
		pud2_r: PULLUP_DISABLE_RESET,
		p0_meta: PORT_ZERO_RESET,
		p0_sync: PORT_ZERO_RESET,
		p1_meta: PORT_ONE_RESET,
		p1_sync: PORT_ONE_RESET,
		p2_meta: PORT_TWO_RESET[P2_PIN_COUNT-1:0],
		p2_sync: PORT_TWO_RESET[P2_PIN_COUNT-1:0],
		rdata: READ_MISS_DATA,
		p0_out: PORT_ZERO_RESET,
		p0_oe: ~PORT_ZERO_RESET,
		p1_out: PORT_ONE_RESET,
		p1_oe: ~PORT_ONE_RESET,
		p2_out: PORT_TWO_RESET[P2_PIN_COUNT-1:0],
		p2_oe: ~PORT_TWO_RESET[P2_PIN_COUNT-1:0],
		p2_pu: ~PULLUP_DISABLE_RESET[P2_PULLUP_COUNT-1:0],
		rst_pu: ~PULLUP_DISABLE_RESET[PUD_RESET_PIN_BIT],
		ea_pu: ~PULLUP_DISABLE_RESET[PUD_EA_PIN_BIT],
		alt_in: '{default: 1'b1}
	};

	state_t st_r;
	state_t st_nxt;

	logic [7:0] bit_mask;
	logic [7:0] bit_sel_addr;
	logic [7:0] p0_drv;
	logic [7:0] p0_alt_en;
	logic [7:0] p0_alt_val;
	logic spi_on_pin;
	logic two_wire_on_pin;

	assign bit_sel_addr = {I_SFR_REQ.bit_addr[BIT_ADDR_SEL_MSB:BIT_ADDR_SEL_LSB], 3'h0};
	assign bit_mask = 8'h01 << I_SFR_REQ.bit_addr[BIT_ADDR_POS_MSB:0];

	// Serial select splits pin 0.4 between SPI and two-wire, so they never overlap
	assign spi_on_pin = I_ALT_CTRL.serial_port_select & I_ALT_CTRL.spi_block_enable;
	assign two_wire_on_pin = ~I_ALT_CTRL.serial_port_select & I_ALT_CTRL.two_wire_enable;

	always_comb begin
		p0_alt_en = 8'h00;
		p0_alt_val = 8'hFF;
		p0_alt_en[P0_SEGMENT_PIN] = I_ALT_CTRL.segment_19_enable;
		p0_alt_val[P0_SEGMENT_PIN] = I_ALT_CTRL.lcd_segment_19;
		p0_alt_en[P0_CALIB_ONE_PIN] = ~I_ALT_CTRL.calib_out_one_disable;
		p0_alt_val[P0_CALIB_ONE_PIN] = I_ALT_CTRL.calib_freq_out_one;
		p0_alt_en[P0_CALIB_TWO_PIN] = ~I_ALT_CTRL.calib_out_two_disable;
		p0_alt_val[P0_CALIB_TWO_PIN] = I_ALT_CTRL.calib_freq_out_two;
		p0_alt_en[P0_SERIAL_DATA_PIN] = spi_on_pin | two_wire_on_pin;
		// SPI takes the pin first should both ever be enabled through a select glitch
		if (spi_on_pin) begin
			p0_alt_val[P0_SERIAL_DATA_PIN] = I_ALT_CTRL.spi_mosi_out;
		end else begin
			p0_alt_val[P0_SERIAL_DATA_PIN] = I_ALT_CTRL.two_wire_data_out;
		end
	end

	always_comb begin
		st_nxt = st_r;

		st_nxt.p0_meta = I_P0_PIN;
		st_nxt.p0_sync = st_r.p0_meta;
		st_nxt.p1_meta = I_P1_PIN;
		st_nxt.p1_sync = st_r.p1_meta;
		st_nxt.p2_meta = I_P2_PIN;
		st_nxt.p2_sync = st_r.p2_meta;

		// Bit write first, a byte write in the same cycle overrides it
		if (I_SFR_REQ.bit_wr) begin
			case (bit_sel_addr)
				PORT_ZERO_LATCH_ADDR: begin
					st_nxt.p0_r = I_SFR_REQ.bit_wdata ? (st_r.p0_r | bit_mask) : (st_r.p0_r & ~bit_mask);
				end
				PORT_ONE_LATCH_ADDR: begin
					st_nxt.p1_r = I_SFR_REQ.bit_wdata ? (st_r.p1_r | bit_mask) : (st_r.p1_r & ~bit_mask);
				end
				PORT_TWO_LATCH_ADDR: begin
					st_nxt.p2_r = I_SFR_REQ.bit_wdata ? (st_r.p2_r | bit_mask) : (st_r.p2_r & ~bit_mask);
				end
				default: begin
				end
			endcase
		end
		if (I_SFR_REQ.wr) begin
			case (I_SFR_REQ.addr)
				PORT_ZERO_LATCH_ADDR: st_nxt.p0_r = I_SFR_REQ.wdata;
				PORT_ONE_LATCH_ADDR: st_nxt.p1_r = I_SFR_REQ.wdata;
				PORT_TWO_LATCH_ADDR: st_nxt.p2_r = I_SFR_REQ.wdata;
				// Reserved bits are not stored, so a careless write cannot reach them
				PORT_TWO_PULLUP_DISABLE_ADDR: st_nxt.pud2_r = I_SFR_REQ.wdata & PULLUP_DISABLE_MASK;
				default: begin
				end
			endcase
		end
		// Unused port-two bits have no latch behind them and always read one
		st_nxt.p2_r = st_nxt.p2_r | PORT_TWO_UNUSED_ONES;

		if (I_SFR_REQ.rd) begin
			case (I_SFR_REQ.addr)
				PORT_ZERO_LATCH_ADDR: begin
					st_nxt.rdata = I_SFR_REQ.rmw ? st_r.p0_r : st_r.p0_sync;
				end
				PORT_ONE_LATCH_ADDR: begin
					st_nxt.rdata = I_SFR_REQ.rmw ? st_r.p1_r : st_r.p1_sync;
				end
				PORT_TWO_LATCH_ADDR: begin
					st_nxt.rdata = I_SFR_REQ.rmw ? st_r.p2_r : (PORT_TWO_UNUSED_ONES | {6'h00, st_r.p2_sync});
				end
				PORT_TWO_PULLUP_DISABLE_ADDR: st_nxt.rdata = st_r.pud2_r;
				default: st_nxt.rdata = READ_MISS_DATA;
			endcase
		end

		// Pins follow the new latch value at the same edge it is stored
		p0_drv = st_nxt.p0_r & (~p0_alt_en | p0_alt_val);
		st_nxt.p0_out = p0_drv;
		st_nxt.p0_oe = ~p0_drv;
		st_nxt.p1_out = st_nxt.p1_r;
		st_nxt.p1_oe = ~st_nxt.p1_r;
		st_nxt.p2_out = st_nxt.p2_r[P2_PIN_COUNT-1:0];
		st_nxt.p2_oe = ~st_nxt.p2_r[P2_PIN_COUNT-1:0];

		st_nxt.p2_pu = ~st_nxt.pud2_r[P2_PULLUP_COUNT-1:0];
		st_nxt.rst_pu = ~st_nxt.pud2_r[PUD_RESET_PIN_BIT];
		st_nxt.ea_pu = ~st_nxt.pud2_r[PUD_EA_PIN_BIT];

		// Inputs forwarded only with latch one; idle level is high otherwise
		st_nxt.alt_in.battery_control_in = 1'b1;
		st_nxt.alt_in.external_irq_one = 1'b1;
		st_nxt.alt_in.battery_sleep_wake = 1'b1;
		st_nxt.alt_in.spi_mosi_in = 1'b1;
		st_nxt.alt_in.two_wire_data_in = 1'b1;
		if (st_r.p0_r[P0_BATTERY_PIN]) begin
			if (I_ALT_CTRL.irq_pin_program_field[1:0] == BATTERY_CTRL_PATTERN) begin
				st_nxt.alt_in.battery_control_in = st_r.p0_sync[P0_BATTERY_PIN];
			end
			if (I_ALT_CTRL.irq_pin_program_field[2:1] == SLEEP_WAKE_PATTERN) begin
				st_nxt.alt_in.battery_sleep_wake = st_r.p0_sync[P0_BATTERY_PIN];
			end
			if (I_ALT_CTRL.external_irq_one_enable) begin
				st_nxt.alt_in.external_irq_one = st_r.p0_sync[P0_BATTERY_PIN];
			end
		end
		if (st_r.p0_r[P0_SERIAL_DATA_PIN]) begin
			if (spi_on_pin) begin
				st_nxt.alt_in.spi_mosi_in = st_r.p0_sync[P0_SERIAL_DATA_PIN];
			end else if (two_wire_on_pin) begin
				st_nxt.alt_in.two_wire_data_in = st_r.p0_sync[P0_SERIAL_DATA_PIN];
			end
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST) begin
			st_r <= STATE_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign O_SFR_RDATA = st_r.rdata;
	assign O_ALT_IN = st_r.alt_in;
	assign O_P0_OUT = st_r.p0_out;
	assign O_P0_OE = st_r.p0_oe;
	assign O_P1_OUT = st_r.p1_out;
	assign O_P1_OE = st_r.p1_oe;
	assign O_P2_OUT = st_r.p2_out;
	assign O_P2_OE = st_r.p2_oe;
	assign O_P2_PULLUP_EN = st_r.p2_pu;
	assign O_RESET_PIN_PULLUP_EN = st_r.rst_pu;
	assign O_EA_PIN_PULLUP_EN = st_r.ea_pu;

	sequence s_pud_write;
		I_SFR_REQ.wr && I_SFR_REQ.addr == PORT_TWO_PULLUP_DISABLE_ADDR;
	endsequence

	property p_reset_pin_pullup;
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		s_pud_write |=> O_RESET_PIN_PULLUP_EN == !$past(I_SFR_REQ.wdata[PUD_RESET_PIN_BIT]);
	endproperty
	a_reset_pin_pullup: assert property (p_reset_pin_pullup) else $error("reset pin pull-up wrong");

	property p_ea_pin_pullup;
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		s_pud_write |=> O_EA_PIN_PULLUP_EN == !$past(I_SFR_REQ.wdata[PUD_EA_PIN_BIT]);
	endproperty
	a_ea_pin_pullup: assert property (p_ea_pin_pullup) else $error("access pin pull-up wrong");

	property p_p2_pullup;
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		s_pud_write |=> O_P2_PULLUP_EN == ~$past(I_SFR_REQ.wdata[P2_PULLUP_COUNT-1:0]);
	endproperty
	a_p2_pullup: assert property (p_p2_pullup) else $error("port two pull-up wrong");

	property p_pud_reserved_zero;
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_SFR_REQ.rd && I_SFR_REQ.addr == PORT_TWO_PULLUP_DISABLE_ADDR |=> (O_SFR_RDATA & ~PULLUP_DISABLE_MASK) == 8'h00;
	endproperty
	a_pud_reserved_zero: assert property (p_pud_reserved_zero) else $error("reserved pull-up bits set");

	sequence s_p0_write_then_rmw;
		I_SFR_REQ.wr && I_SFR_REQ.addr == PORT_ZERO_LATCH_ADDR && !I_SFR_REQ.bit_wr ##1
		!I_SFR_REQ.wr && !I_SFR_REQ.bit_wr ##1
		I_SFR_REQ.rd && I_SFR_REQ.rmw && I_SFR_REQ.addr == PORT_ZERO_LATCH_ADDR && !I_SFR_REQ.wr && !I_SFR_REQ.bit_wr;
	endsequence

	property p_p0_latch_readback;
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		s_p0_write_then_rmw |=> O_SFR_RDATA == $past(I_SFR_REQ.wdata, 3);
	endproperty
	a_p0_latch_readback: assert property (p_p0_latch_readback) else $error("port zero readback wrong");

	property p_p1_bit_write;
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_SFR_REQ.bit_wr && !I_SFR_REQ.wr && bit_sel_addr == PORT_ONE_LATCH_ADDR
		|=> O_P1_OUT[$past(I_SFR_REQ.bit_addr[2:0])] == $past(I_SFR_REQ.bit_wdata);
	endproperty
	a_p1_bit_write: assert property (p_p1_bit_write) else $error("port one bit write lost");

	property p_p2_unused_set;
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_SFR_REQ.rd && I_SFR_REQ.addr == PORT_TWO_LATCH_ADDR |=> O_SFR_RDATA[7:2] == 6'h3F;
	endproperty
	a_p2_unused_set: assert property (p_p2_unused_set) else $error("port two unused bits cleared");

	property p_latch_zero_low;
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_SFR_REQ.wr && I_SFR_REQ.addr == PORT_ZERO_LATCH_ADDR && I_SFR_REQ.wdata == 8'h00
		|=> O_P0_OE == 8'hFF && O_P0_OUT == 8'h00;
	endproperty
	a_latch_zero_low: assert property (p_latch_zero_low) else $error("pin not low with latch zero");

	property p_spi_mosi_drive;
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		spi_on_pin && st_nxt.p0_r[P0_SERIAL_DATA_PIN]
		|=> O_P0_OUT[P0_SERIAL_DATA_PIN] == $past(I_ALT_CTRL.spi_mosi_out);
	endproperty
	a_spi_mosi_drive: assert property (p_spi_mosi_drive) else $error("MOSI not on pin");

	property p_pin_read;
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_SFR_REQ.rd && !I_SFR_REQ.rmw && I_SFR_REQ.addr == PORT_ONE_LATCH_ADDR
		|=> O_SFR_RDATA == $past(I_P1_PIN, 3);
	endproperty
	a_pin_read: assert property (p_pin_read) else $error("pin read wrong");

	property p_p2_pin_drive;
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_SFR_REQ.wr && I_SFR_REQ.addr == PORT_TWO_LATCH_ADDR
		|=> O_P2_OUT == $past(I_SFR_REQ.wdata[P2_PIN_COUNT-1:0]) && O_P2_OE == ~O_P2_OUT;
	endproperty
	a_p2_pin_drive: assert property (p_p2_pin_drive) else $error("port two pins wrong");

	property p_calib_one_drive;
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		!I_ALT_CTRL.calib_out_one_disable && st_nxt.p0_r[P0_CALIB_ONE_PIN]
		|=> O_P0_OUT[P0_CALIB_ONE_PIN] == $past(I_ALT_CTRL.calib_freq_out_one);
	endproperty
	a_calib_one_drive: assert property (p_calib_one_drive) else $error("calibration output not on pin");

	property p_two_wire_drive;
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		two_wire_on_pin && st_nxt.p0_r[P0_SERIAL_DATA_PIN]
		|=> O_P0_OUT[P0_SERIAL_DATA_PIN] == $past(I_ALT_CTRL.two_wire_data_out);
	endproperty
	a_two_wire_drive: assert property (p_two_wire_drive) else $error("two-wire data not on pin");

	// Pin level reaches the forwarded input after two sync flops and one register
	property p_irq_one_forward;
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_ALT_CTRL.external_irq_one_enable && st_r.p0_r[P0_BATTERY_PIN]
		|=> O_ALT_IN.external_irq_one == $past(I_P0_PIN[P0_BATTERY_PIN], 3);
	endproperty
	a_irq_one_forward: assert property (p_irq_one_forward) else $error("interrupt input not forwarded");

	property p_latch_zero_inputs_idle;
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		!st_r.p0_r[P0_BATTERY_PIN]
		|=> O_ALT_IN.battery_control_in && O_ALT_IN.external_irq_one && O_ALT_IN.battery_sleep_wake;
	endproperty
	a_latch_zero_inputs_idle: assert property (p_latch_zero_inputs_idle) else $error("input forwarded with latch zero");

endmodule

// ---- dv/port_pin_world.sv ----
`timescale 1ns/1ps
module port_pin_world (
	input wire logic i_clk,
	input wire logic [7:0] i_zero_oe,
	input wire logic [7:0] i_one_oe,
	input wire logic [1:0] i_two_oe,
	input wire logic [2:0] i_two_pu,
	input wire logic [17:0] i_ext_en,
	input wire logic [17:0] i_ext_val,
	output logic [7:0] o_zero,
	output logic [7:0] o_one,
	output logic [1:0] o_two
);
	logic flip = 1'b0;
	logic [17:0] ext;

	// A released pin with no pull-up keeps no value, so it wanders
	always @(posedge i_clk) begin
		flip <= ~flip;
	end
	assign ext = (i_ext_en & i_ext_val) | ~i_ext_en;
	// Wired-AND: any party pulling low wins; banks zero and one always pulled up
	assign o_zero = ~i_zero_oe & ext[7:0];
	assign o_one = ~i_one_oe & ext[15:8];
	assign o_two = ~i_two_oe & ((i_ext_en[17:16] & i_ext_val[17:16]) |
		(~i_ext_en[17:16] & (i_two_pu[1:0] | {2{flip}})));
endmodule

// ---- dv/tb_port_latch_pullup_altfunc.sv ----
`timescale 1ns/1ps
module tb_port_latch_pullup_altfunc;
	import port_latch_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	sfr_req_t req = '0;
	// Calibration outputs off so the latch alone drives bank zero
	alt_ctrl_t ctl = 15'h0180;
	alt_in_t ain;
	logic [7:0] rdata, pz_out, pz_oe, po_out, po_oe, pin_z, pin_o, d, e;
	logic [1:0] pt_out, pt_oe, pin_t;
	logic [2:0] pt_pu;
	logic rst_pu, acc_pu;
	logic rd_taken = 1'b0;
	logic [17:0] ext_en = '0;
	logic [17:0] ext_val = '0;
	logic [7:0] exp_q[$];
	int err_total = 0;
	int comparisons = 0;
	int i, b;

	initial begin
		forever #5 clk = ~clk;
	end

	port_latch_pullup_altfunc dut (.I_CLK_SYS(clk), .I_SRST(srst), .I_SFR_REQ(req), .O_SFR_RDATA(rdata),
		.I_ALT_CTRL(ctl), .O_ALT_IN(ain), .I_P0_PIN(pin_z), .O_P0_OUT(pz_out), .O_P0_OE(pz_oe),
		.I_P1_PIN(pin_o), .O_P1_OUT(po_out), .O_P1_OE(po_oe), .I_P2_PIN(pin_t), .O_P2_OUT(pt_out),
		.O_P2_OE(pt_oe), .O_P2_PULLUP_EN(pt_pu), .O_RESET_PIN_PULLUP_EN(rst_pu), .O_EA_PIN_PULLUP_EN(acc_pu));

	port_pin_world u_world (.i_clk(clk), .i_zero_oe(pz_oe), .i_one_oe(po_oe), .i_two_oe(pt_oe),
		.i_two_pu(pt_pu), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_zero(pin_z), .o_one(pin_o), .o_two(pin_t));

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// k holds {bit_wr, rmw, rd, wr}; the address doubles as bit address
	task automatic go(input logic [7:0] a, input logic [3:0] k, input logic [7:0] v);
		sfr_req_t r;
		r = '0;
		r.addr = a;
		r.bit_addr = a;
		r.wdata = v;
		r.bit_wdata = v[0];
		{r.bit_wr, r.rmw, r.rd, r.wr} = k;
		@(negedge clk);
		req = r;
		@(negedge clk);
		req = '0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		go(a, 4'h1, v);
	endtask

	task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] exp);
		exp_q.push_back(exp);
		go(a, m ? 4'h6 : 4'h2, 8'h00);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	always @(posedge clk) rd_taken <= req.rd;
	always @(negedge clk) begin
		if (rd_taken === 1'b1) begin
			chk("rdata", rdata, exp_q.pop_front());
		end
	end

	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		$display("[ERR] run_time expected finish seen timeout");
		print_verdict();
	end

	initial begin
		void'($urandom(82975));
		repeat (12) @(negedge clk);
		srst = 1'b0;
		cyc(1);
		chk("zero_out", pz_out, PORT_ZERO_RESET);
		chk("zero_oe", pz_oe, 8'h00);
		chk("one_out", po_out, PORT_ONE_RESET);
		chk("pullup_en", {3'h0, rst_pu, acc_pu, pt_pu}, 8'h1F);
		rd(PORT_ZERO_LATCH_ADDR, 1'b1, 8'hFF);
		rd(PORT_ONE_LATCH_ADDR, 1'b1, 8'hFF);
		rd(PORT_TWO_LATCH_ADDR, 1'b1, PORT_TWO_RESET);
		rd(PORT_TWO_PULLUP_DISABLE_ADDR, 1'b1, 8'h00);
		rd(8'h9F, 1'b1, READ_MISS_DATA);
		$display("test reset done");
		for (i = 0; i < 4; i++) begin
			d = 8'($urandom());
			wr(PORT_ZERO_LATCH_ADDR, d);
			chk("zero_out", pz_out, d);
			chk("zero_oe", pz_oe, ~d);
			rd(PORT_ZERO_LATCH_ADDR, 1'b1, d);
			wr(PORT_ONE_LATCH_ADDR, ~d);
			chk("one_out", po_out, ~d);
			chk("one_oe", po_oe, d);
			rd(PORT_ONE_LATCH_ADDR, 1'b1, ~d);
			wr(PORT_TWO_LATCH_ADDR, d | PORT_TWO_UNUSED_ONES);
			chk("two_out", {6'h00, pt_out}, {6'h00, d[1:0]});
			chk("two_oe", {6'h00, pt_oe}, {6'h00, ~d[1:0]});
			rd(PORT_TWO_LATCH_ADDR, 1'b1, d | PORT_TWO_UNUSED_ONES);
		end
		$display("test byte writes done");
		for (b = 0; b < 3; b++) begin
			e = (b == 0) ? PORT_ZERO_LATCH_ADDR : (b == 1) ? PORT_ONE_LATCH_ADDR : PORT_TWO_LATCH_ADDR;
			wr(e, 8'hFF);
			for (i = 0; i < 8; i++) begin
				go(e + 8'(i), 4'h8, {7'h00, b == 2 && i >= 2});
				d = 8'hFF << (i + 1);
				rd(e, 1'b1, (b == 2) ? d | 8'hFC : d);
			end
		end
		$display("test bit writes done");
		for (b = 0; b < 6; b++) begin
			d = (8'h01 << b) & PULLUP_DISABLE_MASK;
			e = d & PULLUP_DISABLE_MASK;
			wr(PORT_TWO_PULLUP_DISABLE_ADDR, d);
			rd(PORT_TWO_PULLUP_DISABLE_ADDR, 1'b1, e);
			chk("pullup_en", {3'h0, rst_pu, acc_pu, pt_pu}, ~{3'h7, e[5], e[4], e[2:0]});
		end
		wr(PORT_TWO_PULLUP_DISABLE_ADDR, 8'h00);
		$display("test pull-ups done");
		wr(PORT_ZERO_LATCH_ADDR, 8'hFF);
		wr(PORT_ONE_LATCH_ADDR, 8'hFF);
		wr(PORT_TWO_LATCH_ADDR, 8'hFF);
		ext_en = '1;
		ext_val = 18'($urandom());
		cyc(4);
		rd(PORT_ZERO_LATCH_ADDR, 1'b0, ext_val[7:0]);
		rd(PORT_ONE_LATCH_ADDR, 1'b0, ext_val[15:8]);
		rd(PORT_ONE_LATCH_ADDR, 1'b1, 8'hFF);
		rd(PORT_TWO_LATCH_ADDR, 1'b0, {6'h3F, ext_val[17:16]});
		ext_en = 18'h00001;
		ext_val = '0;
		$display("test pin reads done");
		for (i = 0; i < 8; i++) begin
			ctl = alt_ctrl_t'({3'(i), i[0], ctl[10:0]});
			cyc(5);
			chk("alt_in", {3'h0, ain}, {3'h0, i[1:0] != 2'b01, ~i[0], i[2:1] != 2'b11, 2'b11});
		end
		ctl = alt_ctrl_t'({3'b001, 1'b1, ctl[10:0]});
		go(PORT_ZERO_LATCH_ADDR, 4'h8, 8'h00);
		cyc(5);
		chk("alt_in", {3'h0, ain}, 8'h1F);
		ext_en = '0;
		wr(PORT_ZERO_LATCH_ADDR, 8'hFF);
		$display("test alternate inputs done");
		for (i = 0; i < 2; i++) begin
			ctl = alt_ctrl_t'({4'h0, 1'b1, i[0], 2'b00, i[0], ~i[0], 2'b11, i[0], 2'b00});
			cyc(5);
			e = {3'h7, i[0], ~i[0], i[0], i[0], 1'b1};
			chk("zero_out", pz_out, e);
			chk("zero_oe", pz_oe, ~e);
			chk("alt_in", {3'h0, ain}, {3'h0, 3'h7, i[0], 1'b1});
			ctl = alt_ctrl_t'({ctl[14:5], 2'b01, ctl[2], 1'b1, ~i[0]});
			cyc(5);
			chk("zero_out_4", {7'h00, pz_out[4]}, {7'h00, ~i[0]});
			chk("alt_in", {3'h0, ain}, {3'h0, 4'hF, ~i[0]});
		end
		wr(PORT_ZERO_LATCH_ADDR, 8'h00);
		cyc(1);
		chk("zero_out", pz_out, 8'h00);
		$display("test alternate outputs done");
		print_verdict();
	end
endmodule
